/* File: src/rct_regs.svh */
// register offsets, field positions, reset values and codes for ramp control
// assumes an 8-bit register port and a 20 MHz system clock
// Functional notes
// RL1: ramp engine runs only while run bit set
// RL2: run bit forces fractional denominator to 2^24 (code forces 24'hffffff, 2^24-1)
// RL3: divider low byte write starts segment zero (code: only while run bit set)
// RL4: host programs settings before setting run bit
// RL5: clock select picks detector clock or keying pin
// RL6: three 4-bit trigger selectors, reset zero
// RL7: codes 1-3 fire on pin rising edges
// RL8: codes 9-11 fire on pin falling edges
// RL9: never, always, lock, comparator, segment flag codes
// RL10: modulation type bit selects frequency or phase
`ifndef RCT_REGS_SVH
`define RCT_REGS_SVH
`define RCT_ADDR_W 7
`define RCT_OFF_CTRL_A 7'h3a
`define RCT_OFF_TRIG_BC 7'h3b
`define RCT_OFF_N_LOW 7'h10
`define RCT_OFF_DEN_0 7'h11
`define RCT_OFF_DEN_1 7'h12
`define RCT_OFF_DEN_2 7'h13
`define RCT_OFF_STATUS 7'h14
`define RCT_RST_BYTE 8'h00
`define RCT_BIT_RUN 0
`define RCT_BIT_CLKSEL 1
`define RCT_BIT_PM 2
`define RCT_DEN_FIXED 24'hffffff
`define RCT_TRIG_NEVER 4'h0
`define RCT_TRIG_T1_RISE 4'h1
`define RCT_TRIG_T2_RISE 4'h2
`define RCT_TRIG_KEY_RISE 4'h3
`define RCT_TRIG_LOCK_RISE 4'h4
`define RCT_TRIG_COMPARATOR_ZERO_HIT 4'h5
`define RCT_TRIG_GAIN_RISE 4'h6
`define RCT_TRIG_FLAG0_RISE 4'h7
`define RCT_TRIG_ALWAYS 4'h8
`define RCT_TRIG_T1_FALL 4'h9
`define RCT_TRIG_T2_FALL 4'ha
`define RCT_TRIG_KEY_FALL 4'hb
`define RCT_TRIG_LOCK_FALL 4'hc
`endif

/* File: src/rct_pkg.sv */
// types shared by the ramp control block
// assumes rct_regs.svh for numeric constants
package rct_pkg;
	typedef logic [3:0] rct_trig_code_t;
	typedef enum logic [1:0] {
		RCT_IDLE = 2'b00,
		RCT_ARMED = 2'b01,
		RCT_RUNNING = 2'b11
	} rct_state_t;
endpackage

/* File: src/rct_trig_sel.sv */
// one trigger selector: maps a 4-bit code to an edge or level event
// assumes edges are detected by the caller as one-cycle pulses
`timescale 1ns/1ps
`include "rct_regs.svh"
module rct_trig_sel (
	input wire logic [3:0] code,
	input wire logic [7:0] rise,
	input wire logic [7:0] fall,
	input wire logic comparator_zero_hit_level,
	output logic fire
);
	import rct_pkg::*;
	// rise/fall bits: 0 pin one, 1 pin two, 2 keying, 3 lock, 4 gain, 5 flag zero
	always_comb begin
		case (code)
			`RCT_TRIG_NEVER: fire = 1'b0; // [RL9]
			`RCT_TRIG_T1_RISE: fire = rise[0]; // [RL7]
			`RCT_TRIG_T2_RISE: fire = rise[1]; // [RL7]
			`RCT_TRIG_KEY_RISE: fire = rise[2]; // [RL7]
			`RCT_TRIG_LOCK_RISE: fire = rise[3]; // [RL9]
			`RCT_TRIG_COMPARATOR_ZERO_HIT: fire = comparator_zero_hit_level; // [RL9]
			`RCT_TRIG_GAIN_RISE: fire = rise[4]; // [RL9]
			`RCT_TRIG_FLAG0_RISE: fire = rise[5]; // [RL9]
			`RCT_TRIG_ALWAYS: fire = 1'b1; // [RL9]
			`RCT_TRIG_T1_FALL: fire = fall[0]; // [RL8]
			`RCT_TRIG_T2_FALL: fire = fall[1]; // [RL8]
			`RCT_TRIG_KEY_FALL: fire = fall[2]; // [RL8]
			`RCT_TRIG_LOCK_FALL: fire = fall[3]; // [RL9]
			default: fire = 1'b0;
		endcase
	end
endmodule

/* File: src/rct_ramp_ctrl.sv */
// ramp control: run, clock source, modulation type, three trigger selectors
// assumes pins are synchronous to ref_clk; byte-wide register port
`timescale 1ns/1ps
`include "rct_regs.svh"
module rct_ramp_ctrl (
	input wire logic ref_clk,
	input wire logic rst_b,
	input wire logic [6:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	input wire logic trigger_pin_one,
	input wire logic trigger_pin_two,
	input wire logic keying_pin,
	input wire logic digital_lock_flag,
	input wire logic comparator_zero_hit,
	input wire logic segment_gain_flag,
	input wire logic segment_flag_zero,
	input wire logic pd_clk_tick,
	output logic ramp_enable,
	output logic ramp_tick,
	output logic phase_mod_select,
	output logic segment_zero_start,
	output logic [23:0] frac_denominator,
	output logic trigger_a,
	output logic trigger_b,
	output logic trigger_c,
	output rct_pkg::rct_state_t ramp_state
);
	import rct_pkg::*;
	logic [7:0] ctrl_a_reg;
	logic [7:0] trig_bc_reg;
	logic [7:0] n_low_reg;
	logic [23:0] den_reg;
	logic [5:0] pins_reg;
	logic [5:0] pins_now;
	logic [7:0] rise;
	logic [7:0] fall;
	logic fire_a;
	logic fire_b;
	logic fire_c;
	logic start_pulse;
	rct_state_t state_reg;
	rct_state_t state_next;

	function automatic logic hit(input logic [6:0] a, input logic [6:0] off);
		hit = (a == off);
	endfunction

	// register writes
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			ctrl_a_reg <= `RCT_RST_BYTE; // [RL1] [RL6]
			trig_bc_reg <= `RCT_RST_BYTE; // [RL6]
			n_low_reg <= `RCT_RST_BYTE;
			den_reg <= 24'h000000;
		end else if (reg_wr) begin
			if (hit(reg_addr, `RCT_OFF_CTRL_A)) ctrl_a_reg <= reg_wdata;
			if (hit(reg_addr, `RCT_OFF_TRIG_BC)) trig_bc_reg <= reg_wdata;
			if (hit(reg_addr, `RCT_OFF_N_LOW)) n_low_reg <= reg_wdata;
			if (hit(reg_addr, `RCT_OFF_DEN_0)) den_reg[7:0] <= reg_wdata;
			if (hit(reg_addr, `RCT_OFF_DEN_1)) den_reg[15:8] <= reg_wdata;
			if (hit(reg_addr, `RCT_OFF_DEN_2)) den_reg[23:16] <= reg_wdata;
		end
	end

	// read data, one cycle after the strobe
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			reg_rdata <= `RCT_RST_BYTE;
		end else if (reg_rd) begin
			case (reg_addr)
				`RCT_OFF_CTRL_A: reg_rdata <= ctrl_a_reg;
				`RCT_OFF_TRIG_BC: reg_rdata <= trig_bc_reg;
				`RCT_OFF_N_LOW: reg_rdata <= n_low_reg;
				`RCT_OFF_DEN_0: reg_rdata <= den_reg[7:0];
				`RCT_OFF_DEN_1: reg_rdata <= den_reg[15:8];
				`RCT_OFF_DEN_2: reg_rdata <= den_reg[23:16];
				`RCT_OFF_STATUS: reg_rdata <= {3'h0, trigger_c, trigger_b, trigger_a, state_reg};
				default: reg_rdata <= `RCT_RST_BYTE;
			endcase
		end else begin
			reg_rdata <= `RCT_RST_BYTE;
		end
	end

	assign ramp_enable = ctrl_a_reg[`RCT_BIT_RUN]; // [RL1]
	assign phase_mod_select = ctrl_a_reg[`RCT_BIT_PM]; // [RL10]
	// denominator forced while run bit set
	assign frac_denominator = ramp_enable ? `RCT_DEN_FIXED : den_reg; // [RL2]

	// edge detection of pins and flags
	assign pins_now = {segment_flag_zero, segment_gain_flag, digital_lock_flag,
		keying_pin, trigger_pin_two, trigger_pin_one};
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			pins_reg <= 6'h00;
		end else begin
			pins_reg <= pins_now;
		end
	end
	assign rise = {2'h0, pins_now & ~pins_reg};
	assign fall = {2'h0, ~pins_now & pins_reg};

	rct_trig_sel u_sel_a (
		.code(ctrl_a_reg[7:4]),
		.rise(rise),
		.fall(fall),
		.comparator_zero_hit_level(comparator_zero_hit),
		.fire(fire_a)
	);
	rct_trig_sel u_sel_b (
		.code(trig_bc_reg[3:0]),
		.rise(rise),
		.fall(fall),
		.comparator_zero_hit_level(comparator_zero_hit),
		.fire(fire_b)
	);
	rct_trig_sel u_sel_c (
		.code(trig_bc_reg[7:4]),
		.rise(rise),
		.fall(fall),
		.comparator_zero_hit_level(comparator_zero_hit),
		.fire(fire_c)
	);

	// triggers gated by run bit, registered
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			trigger_a <= 1'b0;
			trigger_b <= 1'b0;
			trigger_c <= 1'b0;
		end else begin
			trigger_a <= fire_a & ramp_enable; // [RL6] [RL1]
			trigger_b <= fire_b & ramp_enable; // [RL6]
			trigger_c <= fire_c & ramp_enable; // [RL6]
		end
	end

	// start at segment zero on low divider byte write while run bit set
	assign start_pulse = reg_wr && hit(reg_addr, `RCT_OFF_N_LOW) && ramp_enable; // [RL3]

	always_comb begin
		state_next = state_reg;
		case (state_reg)
			RCT_IDLE: begin
				// a start write right after the run write must not be lost
				if (start_pulse) state_next = RCT_RUNNING; // [RL3]
				else if (ramp_enable) state_next = RCT_ARMED;
			end
			RCT_ARMED: begin
				if (!ramp_enable) state_next = RCT_IDLE;
				else if (start_pulse) state_next = RCT_RUNNING; // [RL3]
			end
			RCT_RUNNING: begin
				if (!ramp_enable) state_next = RCT_IDLE; // [RL1]
			end
			default: state_next = RCT_IDLE;
		endcase
	end

	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			state_reg <= RCT_IDLE;
			segment_zero_start <= 1'b0;
		end else begin
			state_reg <= state_next;
			segment_zero_start <= start_pulse; // [RL3]
		end
	end
	assign ramp_state = state_reg;

	// ramp clock: detector tick or keying rising edge, only while running
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			ramp_tick <= 1'b0;
		end else begin
			ramp_tick <= (state_reg == RCT_RUNNING) && ramp_enable &&
				(ctrl_a_reg[`RCT_BIT_CLKSEL] ? rise[2] : pd_clk_tick); // [RL5] [RL1]
		end
	end

	a_den_forced: assert property (@(posedge ref_clk) disable iff (!rst_b)
		ramp_enable |-> frac_denominator == `RCT_DEN_FIXED) // [RL2]
		else $error("denominator not forced");
	a_start_pulse: assert property (@(posedge ref_clk) disable iff (!rst_b)
		(reg_wr && reg_addr == `RCT_OFF_N_LOW && ramp_enable) |=> segment_zero_start) // [RL3]
		else $error("start missing");
	a_state_idle: assert property (@(posedge ref_clk) disable iff (!rst_b)
		!ramp_enable |=> state_reg == RCT_IDLE) // [RL1]
		else $error("state not idle while disabled");
	a_trig_gated: assert property (@(posedge ref_clk) disable iff (!rst_b)
		!ramp_enable |=> !(trigger_a || trigger_b || trigger_c)) // [RL1]
		else $error("trigger while disabled");
	a_trig_never: assert property (@(posedge ref_clk) disable iff (!rst_b)
		ctrl_a_reg[7:4] == `RCT_TRIG_NEVER |=> !trigger_a) // [RL9]
		else $error("never code triggered");
	a_rdata_idle: assert property (@(posedge ref_clk) disable iff (!rst_b)
		!reg_rd |=> reg_rdata == `RCT_RST_BYTE)
		else $error("read data outside read cycle");
	a_tick_off: assert property (@(posedge ref_clk) disable iff (!rst_b)
		!ramp_enable |=> !ramp_tick) // [RL1]
		else $error("tick while disabled");
	a_trig_rise: assert property (@(posedge ref_clk) disable iff (!rst_b)
		(ctrl_a_reg[7:4] == 4'h1 && ramp_enable && trigger_pin_one && !$past(trigger_pin_one))
		|=> trigger_a) // [RL7]
		else $error("rise trigger missed");
	a_trig_fall: assert property (@(posedge ref_clk) disable iff (!rst_b)
		(trig_bc_reg[3:0] == 4'h9 && ramp_enable && !trigger_pin_one && $past(trigger_pin_one))
		|=> trigger_b) // [RL8]
		else $error("fall trigger missed");
	a_trig_always: assert property (@(posedge ref_clk) disable iff (!rst_b)
		(trig_bc_reg[7:4] == 4'h8 && ramp_enable) |=> trigger_c) // [RL9]
		else $error("always trigger missed");
	a_clk_key: assert property (@(posedge ref_clk) disable iff (!rst_b)
		(ctrl_a_reg[`RCT_BIT_CLKSEL] && ramp_enable && state_reg == RCT_RUNNING &&
		keying_pin && !$past(keying_pin))
		|=> ramp_tick) // [RL5]
		else $error("keying tick missed");
	a_pm_follow: assert property (@(posedge ref_clk) disable iff (!rst_b)
		(reg_wr && reg_addr == `RCT_OFF_CTRL_A) |=>
		phase_mod_select == $past(reg_wdata[`RCT_BIT_PM])) // [RL10]
		else $error("modulation type wrong");
endmodule

/* File: testbench/rct_pins_model.sv */
// pin and detector-clock model facing the ramp control block
// assumes bench commands arrive synchronous to ref_clk
`timescale 1ns/1ps
module rct_pins_model (
	input wire logic ref_clk,
	input wire logic rst_b,
	input wire logic [6:0] pin_cmd,
	input wire logic tick_en,
	output logic trigger_pin_one,
	output logic trigger_pin_two,
	output logic keying_pin,
	output logic digital_lock_flag,
	output logic comparator_zero_hit,
	output logic segment_gain_flag,
	output logic segment_flag_zero,
	output logic pd_clk_tick
);
	logic [6:0] pin_reg;
	logic [1:0] div_reg;
	// pins follow the bench command one edge later
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) pin_reg <= 7'h00;
		else pin_reg <= pin_cmd;
	end
	assign {segment_flag_zero, segment_gain_flag, comparator_zero_hit, digital_lock_flag,
		keying_pin, trigger_pin_two, trigger_pin_one} = pin_reg;
	// detector clock pulse every fourth cycle
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) div_reg <= 2'h0;
		else div_reg <= div_reg + 2'h1;
	end
	assign pd_clk_tick = tick_en && div_reg == 2'h0;
endmodule

/* File: testbench/rct_ramp_ctrl_test.sv */
// bench top: register tasks, trigger code sweep, ramp clock and denominator checks
// assumes rct_pins_model drives the pins of rct_ramp_ctrl
`timescale 1ns/1ps
module rct_ramp_ctrl_test;
	import rct_pkg::*;
	logic ref_clk = 0, rst_b = 0, reg_wr = 0, reg_rd = 0, tick_en = 0;
	logic [6:0] reg_addr = 0, pin_cmd = 0;
	logic [7:0] reg_wdata = 0, reg_rdata;
	logic t1, t2, key, lock, cmp, gain, flg, pd, ren, rtk, pm, szs, ta, tb, tc;
	logic [23:0] den;
	rct_state_t st;
	int mismatches = 0, tests_run = 0, ca, cb, cc, n;
	logic [3:0] codes [13] = '{0, 1, 2, 3, 4, 6, 7, 9, 10, 11, 12, 5, 8};
	logic [6:0] pfrom [13] = '{0, 0, 0, 0, 0, 0, 0, 1, 2, 4, 8, 0, 0};
	logic [6:0] pto [13] = '{7'h7f, 1, 2, 4, 8, 7'h20, 7'h40, 0, 0, 0, 0, 7'h10, 0};
	always #25 ref_clk = ~ref_clk;
	rct_pins_model pins (.ref_clk(ref_clk), .rst_b(rst_b), .pin_cmd(pin_cmd),
		.tick_en(tick_en), .trigger_pin_one(t1), .trigger_pin_two(t2), .keying_pin(key),
		.digital_lock_flag(lock), .comparator_zero_hit(cmp), .segment_gain_flag(gain),
		.segment_flag_zero(flg), .pd_clk_tick(pd));
	rct_ramp_ctrl dut (.ref_clk(ref_clk), .rst_b(rst_b), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.trigger_pin_one(t1), .trigger_pin_two(t2), .keying_pin(key),
		.digital_lock_flag(lock), .comparator_zero_hit(cmp), .segment_gain_flag(gain),
		.segment_flag_zero(flg), .pd_clk_tick(pd), .ramp_enable(ren), .ramp_tick(rtk),
		.phase_mod_select(pm), .segment_zero_start(szs), .frac_denominator(den),
		.trigger_a(ta), .trigger_b(tb), .trigger_c(tc), .ramp_state(st));
	task chk(input logic [23:0] got, input logic [23:0] exp);
		tests_run++;
		if (got !== exp) begin
			mismatches++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task wr(input logic [6:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
		#1;
	endtask
	task rd(input logic [6:0] a, input logic [7:0] exp);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		#1;
		chk(reg_rdata, exp);
	endtask
	// drive a pin pattern and count trigger and tick pulses over five cycles
	task apply(input logic [6:0] p);
		@(posedge ref_clk);
		pin_cmd <= p;
		{ca, cb, cc, n} = '0;
		repeat (5) begin
			@(posedge ref_clk);
			#1;
			ca += ta;
			cb += tb;
			cc += tc;
			n += rtk;
		end
	endtask
	task conclude;
		$display("mismatches=%0d tests_run=%0d", mismatches, tests_run);
		if (mismatches == 0 && tests_run > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	initial begin
		#5000000;
		mismatches++;
		conclude;
	end
	initial begin
		repeat (5) @(posedge ref_clk);
		rst_b <= 1'b1;
		rd(7'h3a, 8'h00);
		rd(7'h3b, 8'h00);
		rd(7'h7f, 8'h00);
		wr(7'h11, 8'h56);
		wr(7'h12, 8'h34);
		wr(7'h13, 8'h12);
		chk(den, 24'h123456);
		wr(7'h3a, 8'h84);
		chk(pm, 1'b1);
		apply(7'h00);
		chk(ta, 1'b0);
		wr(7'h3a, 8'h01); // setup done before run
		chk(den, 24'hffffff);
		chk(ren, 1'b1);
		rd(7'h3a, 8'h01);
		wr(7'h10, 8'h00);
		chk(szs, 1'b1);
		chk(st, RCT_RUNNING);
		tick_en <= 1'b1;
		repeat (3) @(posedge ref_clk);
		n = 0;
		repeat (16) begin
			@(posedge ref_clk);
			#1;
			n += rtk;
		end
		chk(n, 4);
		wr(7'h3a, 8'h03);
		apply(7'h00);
		apply(7'h04);
		chk(n, 1);
		for (int i = 0; i < 13; i++) begin
			apply(pfrom[i]);
			wr(7'h3a, {codes[i], 4'h1});
			wr(7'h3b, {codes[i], codes[i]});
			rd(7'h3b, {codes[i], codes[i]});
			apply(pto[i]);
			if (i > 10) chk({ta, tb, tc}, 3'h7);
			else chk({ca[3:0], cb[3:0], cc[3:0]}, i == 0 ? 12'h000 : 12'h111);
		end
		rd(7'h14, 8'h1f);
		rd(7'h11, 8'h56);
		rd(7'h13, 8'h12);
		wr(7'h3a, 8'h84);
		chk(ren, 1'b0);
		chk(pm, 1'b1);
		chk(den, 24'h123456);
		@(posedge ref_clk);
		#1;
		chk(st, RCT_IDLE);
		chk({ta, tb, tc}, 3'h0);
		wr(7'h10, 8'h00);
		chk(szs, 1'b0);
		@(posedge ref_clk);
		rst_b <= 1'b0;
		repeat (2) @(posedge ref_clk);
		rst_b <= 1'b1;
		rd(7'h3a, 8'h00);
		rd(7'h3b, 8'h00);
		chk(pm, 1'b0);
		chk(ren, 1'b0);
		chk(den, 24'h000000);
		conclude;
	end
endmodule
